// ### hw/ldcc_top.v
/*
 * led drive current configuration register bank with proximity mode selection.
 * assumes a byte register port fed by the serial interface front end, a pulse
 * start strobe from the led timing logic and channel 1 adc results.
 */
// Notes on behaviour
// - code zero gives zero current; each step adds one lsb; max gives full scale
// - channel 2 range code 00..11 selects 50, 100, 150, 200 mA full scale
// - channel 1 range sits in range register bits 1:0, same encoding
// - in proximity mode channel 1 uses pilot code scaled by channel 1 range
// - identifier register at top address is read only, fixed, ignores writes
// - leave proximity mode when adc upper eight bits reach programmed threshold
`timescale 1ns/10ps
`include "ldcc_regs.vh"

module ldcc_top #(
    // arbitrary neutral value, not a real part code
    parameter [7:0] DEVICE_IDENTIFIER = 8'h5a
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // register port
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [7:0]  i_reg_addr,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    output reg         o_reg_rvalid,
    // proximity control
    input  wire        i_prox_enable,
    input  wire        i_adc_valid,
    input  wire [18:0] i_adc_data,
    output reg         o_prox_mode,
    output reg         o_prox_event,
    // led timing
    input  wire        i_pulse_start,
    // drive outputs
    output reg  [17:0] o_led1_drive_output,
    output reg  [17:0] o_led2_drive_output,
    output reg  [7:0]  o_chan1_code_active,
    output reg  [7:0]  o_chan2_code_active
);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    reg [7:0] proximity_threshold;
    reg [7:0] chan1_amplitude_code;
    reg [7:0] chan2_amplitude_code;
    reg [7:0] led_current_range;
    reg [7:0] proximity_amplitude_code;

    always @(posedge i_clk) begin
        if (i_rst) begin
            proximity_threshold      <= `LDCC_RST_PROX_THRESH;
            chan1_amplitude_code     <= `LDCC_RST_CHAN1_AMP;
            chan2_amplitude_code     <= `LDCC_RST_CHAN2_AMP;
            led_current_range        <= `LDCC_RST_RANGE;
            proximity_amplitude_code <= `LDCC_RST_PILOT_AMP;
        end else if (i_reg_wr) begin
            // identifier address has no write case, so writes there drop
            case (i_reg_addr)
                `LDCC_ADDR_PROX_THRESH: begin
                    proximity_threshold <= i_reg_wdata;
                end
                `LDCC_ADDR_CHAN1_AMP: begin
                    chan1_amplitude_code <= i_reg_wdata;
                end
                `LDCC_ADDR_CHAN2_AMP: begin
                    chan2_amplitude_code <= i_reg_wdata;
                end
                `LDCC_ADDR_RANGE: begin
                    // unused upper bits are stored as zero
                    led_current_range <= i_reg_wdata & `LDCC_RANGE_USED_MASK;
                end
                `LDCC_ADDR_PILOT_AMP: begin
                    proximity_amplitude_code <= i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    reg [7:0] next_rdata;

    always @* begin
        case (i_reg_addr)
            `LDCC_ADDR_PROX_THRESH: next_rdata = proximity_threshold;
            `LDCC_ADDR_CHAN1_AMP:   next_rdata = chan1_amplitude_code;
            `LDCC_ADDR_CHAN2_AMP:   next_rdata = chan2_amplitude_code;
            `LDCC_ADDR_RANGE:       next_rdata = led_current_range;
            `LDCC_ADDR_PILOT_AMP:   next_rdata = proximity_amplitude_code;
            `LDCC_ADDR_DEVICE_IDENTIFIER:     next_rdata = DEVICE_IDENTIFIER;
            // unmapped addresses read back as zero
            default:                next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            // read data holds until the next read
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // proximity mode
    // ----------------------------------------------------------------
    wire [7:0] adc_upper;
    wire       prox_hit;
    wire       prox_enable_rise;
    reg        prox_enable_q;

    assign adc_upper        = i_adc_data[`LDCC_ADC_MSB:`LDCC_ADC_CMP_LSB];
    // a threshold of one matches any count of 2048 or more
    assign prox_hit         = i_adc_valid && (adc_upper >= proximity_threshold);
    assign prox_enable_rise = i_prox_enable && !prox_enable_q;

    // enable edge detector; resets to the idle level, so an enable held high through reset counts as a rise and enters
    always @(posedge i_clk) begin
        if (i_rst) begin
            prox_enable_q <= 1'b0;
        end else begin
            prox_enable_q <= i_prox_enable;
        end
    end

    // event is a one-cycle pulse on each threshold exit; dropping out by disabling gives none

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prox_mode  <= 1'b0;
            o_prox_event <= 1'b0;
        end else begin
            o_prox_event <= 1'b0;
            if (!i_prox_enable) begin
                // disabling proximity always drops back to normal mode
                o_prox_mode <= 1'b0;
            end else if (o_prox_mode && prox_hit) begin
                o_prox_mode  <= 1'b0;
                o_prox_event <= 1'b1;
            end else if (prox_enable_rise) begin
                // entering proximity mode swaps channel 1 onto the pilot code
                o_prox_mode <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // pulse-latched codes and scaling
    // ----------------------------------------------------------------
    reg  [1:0]  chan1_range_active;
    reg  [1:0]  chan2_range_active;
    wire [15:0] code_bus;
    wire [3:0]  range_bus;
    wire [35:0] ua_bus;
    wire [17:0] led1_ua;
    wire [17:0] led2_ua;

    // codes and ranges are sampled only at pulse start,
    // so a pulse already in flight keeps its current
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_chan1_code_active <= 8'h00;
            o_chan2_code_active <= 8'h00;
            chan1_range_active  <= 2'b00;
            chan2_range_active  <= 2'b00;
        end else if (i_pulse_start) begin
            o_chan1_code_active <= o_prox_mode ? proximity_amplitude_code
                                               : chan1_amplitude_code;
            o_chan2_code_active <= chan2_amplitude_code;
            chan1_range_active  <= led_current_range[`LDCC_RANGE_CHAN1_MSB:`LDCC_RANGE_CHAN1_LSB];
            chan2_range_active  <= led_current_range[`LDCC_RANGE_CHAN2_MSB:`LDCC_RANGE_CHAN2_LSB];
        end
    end

    // ----------------------------------------------------------------
    // per channel current scaling
    // ----------------------------------------------------------------
    // channel 1 rides in the low slice of each bus, channel 2 in the high
    assign code_bus  = {o_chan2_code_active, o_chan1_code_active};
    assign range_bus = {chan2_range_active, chan1_range_active};
    assign led1_ua   = ua_bus[17:0];
    assign led2_ua   = ua_bus[35:18];

    // each scaler is combinational; the latches above hold its inputs
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_scale
            ldcc_chan_scale u_scale (
                .i_code       (code_bus[8*ch +: 8]),
                .i_range      (range_bus[2*ch +: 2]),
                .o_current_ua (ua_bus[18*ch +: 18])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // drive outputs
    // ----------------------------------------------------------------
    // one register stage so the drive ports come straight from flops

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_led1_drive_output <= 18'h00000;
            o_led2_drive_output <= 18'h00000;
        end else begin
            o_led1_drive_output <= led1_ua;
            o_led2_drive_output <= led2_ua;
        end
    end

endmodule

// ### hw/ldcc_regs.vh
/*
 * register offsets, field positions, reset values and current scale constants
 * for the led drive current configuration block.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef LDCC_REGS_VH
`define LDCC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LDCC_ADDR_PROX_THRESH   8'h10
`define LDCC_ADDR_CHAN1_AMP     8'h11
`define LDCC_ADDR_CHAN2_AMP     8'h12
`define LDCC_ADDR_RANGE         8'h14
`define LDCC_ADDR_PILOT_AMP     8'h15
`define LDCC_ADDR_DEVICE_IDENTIFIER       8'hff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LDCC_RST_PROX_THRESH    8'h00
`define LDCC_RST_CHAN1_AMP      8'h00
`define LDCC_RST_CHAN2_AMP      8'h00
`define LDCC_RST_RANGE          8'h00
`define LDCC_RST_PILOT_AMP      8'h00

// ----------------------------------------------------------------
// range register fields
// ----------------------------------------------------------------
`define LDCC_RANGE_CHAN1_LSB    0
`define LDCC_RANGE_CHAN1_MSB    1
`define LDCC_RANGE_CHAN2_LSB    2
`define LDCC_RANGE_CHAN2_MSB    3
`define LDCC_RANGE_USED_MASK    8'h0f

// ----------------------------------------------------------------
// current scale: drive is code * (range + 1) * 50 mA / 255, in uA
// ----------------------------------------------------------------
`define LDCC_FS_STEP_UA         18'd50000
`define LDCC_CODE_MAX           8'hff

// ----------------------------------------------------------------
// proximity threshold compares upper eight of 19 adc bits
// ----------------------------------------------------------------
`define LDCC_ADC_MSB            18
`define LDCC_ADC_CMP_LSB        11

`endif

// ### hw/ldcc_chan_scale.v
/*
 * one led channel current scaler: turns an amplitude code and a range code
 * into a drive current in microamps.
 * assumes inputs are already held stable for the pulse by the caller.
 */
`timescale 1ns/10ps
`include "ldcc_regs.vh"

module ldcc_chan_scale (
    // codes
    input  wire [7:0]  i_code,
    input  wire [1:0]  i_range,
    // result
    output wire [17:0] o_current_ua
);
    wire [17:0] fs_ua;
    wire [25:0] product;
    wire [25:0] quotient;

    // full scale 50/100/150/200 mA from range 00..11
    assign fs_ua = `LDCC_FS_STEP_UA * ({16'h0000, i_range} + 18'h00001);
    // zero code gives zero, max code gives full scale, linear steps
    assign product = fs_ua * {18'h00000, i_code};
    assign quotient     = product / {18'h00000, `LDCC_CODE_MAX};
    // full scale is at most 200000 uA, so the upper quotient bits stay zero
    assign o_current_ua = quotient[17:0];
endmodule

// ### tb/ldcc_checker.sv
/* port checker for the led current bank.
   assumes one clock and sync active high reset. */
`timescale 1ns/10ps
module ldcc_checker #(
    parameter [7:0] DEVICE_IDENTIFIER = 8'h5a
) (
    // clock, reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // inputs watched
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_pulse_start,
    input wire logic        i_prox_enable,
    input wire logic        i_adc_valid,
    input wire logic [18:0] i_adc_data,
    // outputs watched
    input wire logic        o_reg_rvalid,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_prox_mode,
    input wire logic        o_prox_event,
    input wire logic [17:0] o_led2_drive_output,
    input wire logic [7:0]  o_chan2_code_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rv;
        i_reg_rd |=> o_reg_rvalid;
    endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_id;
        i_reg_rd && i_reg_addr == 8'hff |=> o_reg_rdata == DEVICE_IDENTIFIER;
    endproperty
    a_id: assert property (p_id) else $error("identifier wrong");
    property p_code;
        !i_pulse_start |=> $stable(o_chan2_code_active);
    endproperty
    a_code: assert property (p_code) else $error("code moved");
    property p_drv;
        !i_pulse_start ##1 !i_pulse_start |=> $stable(o_led2_drive_output);
    endproperty
    a_drv: assert property (p_drv) else $error("drive moved");
    property p_zero;
        i_pulse_start ##1 o_chan2_code_active == 8'h00 |=> o_led2_drive_output == 18'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero code drives");
    property p_fs;
        o_led2_drive_output <= 18'd200000;
    endproperty
    a_fs: assert property (p_fs) else $error("above full scale");
    property p_exit;
        o_prox_mode && i_prox_enable && i_adc_valid && i_adc_data[18:11] == 8'hff
            |=> !o_prox_mode && o_prox_event;
    endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_ev;
        o_prox_event |=> !o_prox_event;
    endproperty
    a_ev: assert property (p_ev) else $error("event too long");
    property p_enter;
        $rose(i_prox_enable) |=> o_prox_mode;
    endproperty
    a_enter: assert property (p_enter) else $error("proximity mode not entered");
    property p_off;
        !i_prox_enable |=> !o_prox_mode;
    endproperty
    a_off: assert property (p_off) else $error("mode kept while disabled");
    property p_evsrc;
        o_prox_event |-> $past(o_prox_mode) && !o_prox_mode;
    endproperty
    a_evsrc: assert property (p_evsrc) else $error("event without exit");
endmodule
bind ldcc_top ldcc_checker #(
    .DEVICE_IDENTIFIER(DEVICE_IDENTIFIER)
) u_chk (
    .i_clk, .i_rst, .i_reg_rd, .i_reg_addr, .i_pulse_start, .i_prox_enable, .i_adc_valid,
    .i_adc_data, .o_reg_rvalid, .o_reg_rdata, .o_prox_mode, .o_prox_event,
    .o_led2_drive_output, .o_chan2_code_active
);

// ### tb/ldcc_host.sv
/* host model: byte register master.
   assumes the bench clock; drives on falling edges. */
`timescale 1ns/10ps
module ldcc_host (
    // clock and answer
    input  wire logic       i_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    // request
    output logic            o_wr = 1'b0,
    output logic            o_rd = 1'b0,
    output logic [7:0]      o_addr = 8'h00,
    output logic [7:0]      o_wdata = 8'h00
);
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            ok = (i_rvalid === 1'b1);
            d = i_rdata;
            if (!ok) @(negedge i_clk);
        end
    endtask
endmodule

// ### tb/tb.sv
/* self-checking bench for the led current bank.
   assumes the host model drives the register port. */
`timescale 1ns/10ps
`include "ldcc_regs.vh"
module tb;
    localparam [7:0] ID = 8'h5a; // arbitrary value
    logic        i_clk = 0, i_rst = 1, i_prox_enable = 0, i_adc_valid = 0, i_pulse_start = 0;
    logic [18:0] i_adc_data = 0;
    wire         wr, rd, rv, pm, pe;
    wire [7:0]   ad, wd, rdat, c1, c2;
    wire [17:0]  d1, d2;
    int          n_fail = 0, tests_run = 0;
    always #12.5 i_clk = ~i_clk;
    ldcc_host u_host (.i_clk(i_clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
        .o_addr(ad), .o_wdata(wd));
    ldcc_top #(.DEVICE_IDENTIFIER(ID)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .i_prox_enable(i_prox_enable), .i_adc_valid(i_adc_valid), .i_adc_data(i_adc_data),
        .o_prox_mode(pm), .o_prox_event(pe), .i_pulse_start(i_pulse_start),
        .o_led1_drive_output(d1), .o_led2_drive_output(d2), .o_chan1_code_active(c1),
        .o_chan2_code_active(c2));
    function logic [17:0] ua(int c, int r);
        return 18'(c * (r + 1) * 50000 / 255);
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(string nm, logic [17:0] s, logic [17:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rchk(logic [7:0] a, logic [7:0] e);
        logic [7:0] v;
        bit ok;
        u_host.rd(a, v, ok);
        if (!ok) begin
            n_fail++;
            report_and_stop;
        end else begin
            chk("rdata", {10'h0, v}, {10'h0, e});
        end
    endtask
    task pulse(logic [17:0] e1, logic [17:0] e2);
        @(negedge i_clk) i_pulse_start = 1;
        @(negedge i_clk) i_pulse_start = 0;
        repeat (2) @(negedge i_clk);
        chk("led1", d1, e1);
        chk("led2", d2, e2);
    endtask
    task t_regs;
        rchk(`LDCC_ADDR_RANGE, 8'h00);
        rchk(`LDCC_ADDR_PILOT_AMP, 8'h00);
        u_host.wr(`LDCC_ADDR_DEVICE_IDENTIFIER, 8'h00);
        rchk(`LDCC_ADDR_DEVICE_IDENTIFIER, ID);
        rchk(8'h13, 8'h00);
        u_host.wr(`LDCC_ADDR_RANGE, 8'hff);
        rchk(`LDCC_ADDR_RANGE, 8'h0f);
    endtask
    task t_scale;
        for (int r = 0; r < 4; r++) begin
            u_host.wr(`LDCC_ADDR_CHAN1_AMP, 8'h01);
            u_host.wr(`LDCC_ADDR_CHAN2_AMP, 8'hff);
            u_host.wr(`LDCC_ADDR_RANGE, 8'(r * 5));
            pulse(ua(1, r), ua(255, r));
        end
        u_host.wr(`LDCC_ADDR_CHAN2_AMP, 8'h00);
        pulse(ua(1, 3), 18'h0);
        u_host.wr(`LDCC_ADDR_CHAN2_AMP, 8'h80);
        repeat (3) @(negedge i_clk);
        chk("hold", d2, 18'h0);
        pulse(ua(1, 3), ua(128, 3));
    endtask
    task t_prox;
        u_host.wr(`LDCC_ADDR_PROX_THRESH, 8'hff);
        u_host.wr(`LDCC_ADDR_PILOT_AMP, 8'h80);
        u_host.wr(`LDCC_ADDR_RANGE, 8'h00);
        @(negedge i_clk) i_prox_enable = 1;
        repeat (2) @(negedge i_clk);
        chk("mode", pm, 1);
        pulse(ua(128, 0), ua(128, 0));
        chk("code1", {10'h0, c1}, 18'h80);
        for (int k = 0; k < 2; k++) begin
            @(negedge i_clk) i_adc_valid = 1;
            i_adc_data = k ? 19'h7f800 : 19'h7f7ff;
            @(negedge i_clk) i_adc_valid = 0;
            chk("exit", pm, !k);
            chk("event", pe, 18'(k));
        end
        pulse(ua(1, 0), ua(128, 0));
        u_host.wr(`LDCC_ADDR_PROX_THRESH, 8'h01);
        @(negedge i_clk) i_prox_enable = 0;
        @(negedge i_clk) i_prox_enable = 1;
        repeat (2) @(negedge i_clk);
        chk("reenter", pm, 18'h1);
        for (int k = 0; k < 2; k++) begin
            @(negedge i_clk) i_adc_valid = 1;
            i_adc_data = k ? 19'h00800 : 19'h007ff;
            @(negedge i_clk) i_adc_valid = 0;
            chk("thresh", pm, 18'(!k));
        end
    endtask
    initial begin
        repeat (6) @(negedge i_clk);
        i_rst = 0;
        t_regs;
        t_scale;
        t_prox;
        report_and_stop;
    end
endmodule
